// ==== sim/exec_partner.sv ====
`timescale 1ns/1ps

module exec_partner
    import exec_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [20:0] prog_addr,
    output logic [15:0]      prog_data,
    input  wire dm_req_t     dm_req,
    output logic [7:0]       dm_rdata,
    input  wire stack_push_t return_stack_top,
    input  wire logic        watchdog_clear,
    input  wire q_phase_t    phase
);
    logic [7:0]  dmem [4096];
    logic [20:0] fetch_log [64];
    logic [20:0] push_log [4];
    int          n_fetch;
    int          n_push;
    int          n_kick;

    // ----------------------------------------
    // Program memory, combinational
    // ----------------------------------------
    always_comb begin
        case (prog_addr)
            21'h000040: prog_data = 16'hE005;
            21'h000042: prog_data = 16'h6B20;
            21'h000044: prog_data = 16'hE003;
            21'h000046, 21'h000048, 21'h00004A: prog_data = 16'h6A10;
            21'h00004C: prog_data = 16'h6A90;
            21'h00004E: prog_data = 16'h6A30;
            21'h000050: prog_data = 16'h1F40;
            21'h000052: prog_data = 16'h1D41;
            21'h000054: prog_data = 16'hED45;
            21'h000056: prog_data = 16'hF123;
            21'h02468A: prog_data = 16'h0004;
            21'h02468C: prog_data = 16'h6A50;
            21'h02468E: prog_data = 16'hE0F0;
            21'h024670: prog_data = 16'hEC00;
            21'h024672: prog_data = 16'hF001;
            default:    prog_data = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // Data memory, one cycle read latency
    // ----------------------------------------
    initial begin
        foreach (dmem[i]) dmem[i] = 8'hC3;
        dmem[12'h320] = 8'hA5;
        dmem[12'h410] = 8'h77;
        dmem[12'hF90] = 8'h11;
        dmem[12'h430] = 8'h22;
        dmem[12'h030] = 8'h33;
        dmem[12'h340] = 8'h13;
        dmem[12'h341] = 8'h0F;
        dmem[12'h450] = 8'h66;
    end

    always @(posedge ref_clk) begin
        dm_rdata <= dmem[dm_req.addr];
        if (dm_req.we === 1'b1) begin
            dmem[dm_req.addr] <= dm_req.wdata;
        end
    end

    // ----------------------------------------
    // Fetch, push and watchdog logs
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_fetch <= 0;
            n_push  <= 0;
            n_kick  <= 0;
        end else begin
            if (phase === q1_decode && n_fetch < 64) begin
                fetch_log[n_fetch] <= prog_addr;
                n_fetch            <= n_fetch + 1;
            end
            if (return_stack_top.valid === 1'b1 && n_push < 4) begin
                push_log[n_push] <= return_stack_top.addr;
                n_push           <= n_push + 1;
            end
            if (watchdog_clear === 1'b1) begin
                n_kick <= n_kick + 1;
            end
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "bcce_regs.svh"

module tb_top
    import exec_pkg::*;
;
    logic        ref_clk;
    logic        rst_n;
    logic [20:0] prog_addr;
    logic [15:0] prog_data;
    dm_req_t     dm_req;
    logic [7:0]  dm_rdata;
    logic [11:0] index_base;
    stack_push_t return_stack_top;
    logic        watchdog_clear;
    logic        timeout_flag_n;
    logic        powerdown_flag_n;
    q_phase_t    phase;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    int          fails;
    int          n_checks;
    logic [20:0] exp_trace [17];
    logic [11:0] dm_addr [8];
    logic [7:0]  dm_exp [8];

    branch_call_clear_exec u_branch_call_clear_exec (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .prog_addr        (prog_addr),
        .prog_data        (prog_data),
        .dm_req           (dm_req),
        .dm_rdata         (dm_rdata),
        .index_base       (index_base),
        .return_stack_top (return_stack_top),
        .watchdog_clear   (watchdog_clear),
        .timeout_flag_n   (timeout_flag_n),
        .powerdown_flag_n (powerdown_flag_n),
        .phase            (phase),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata)
    );

    exec_partner u_exec_partner (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .prog_addr        (prog_addr),
        .prog_data        (prog_data),
        .dm_req           (dm_req),
        .dm_rdata         (dm_rdata),
        .return_stack_top (return_stack_top),
        .watchdog_clear   (watchdog_clear),
        .phase            (phase)
    );

    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic close_out();
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        ref_clk    = 1'b0;
        rst_n      = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h00000000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        index_base = 12'h400;
        fails      = 0;
        n_checks   = 0;
        exp_trace  = '{21'h40, 21'h42, 21'h44, 21'h4C, 21'h4C, 21'h4E, 21'h50, 21'h52,
                       21'h54, 21'h2468A, 21'h2468A, 21'h2468C, 21'h2468E, 21'h24670,
                       21'h24670, 21'h200, 21'h200};
        dm_addr    = '{12'h320, 12'h410, 12'hF90, 12'h430, 12'h030, 12'h340, 12'h341,
                       12'h450};
        dm_exp     = '{8'h00, 8'h77, 8'h00, 8'h00, 8'h33, 8'hEC, 8'h0F, 8'h00};
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Setup runs while the core executes leading no-op words
        reg_check(`REG_PC, 32'h00000002);
        reg_check(`REG_CTRL, 32'h00000000);
        reg_check(`REG_ACC, 32'h00000000);
        reg_check(`REG_FLAGS, 32'h00000000);
        reg_check(`REG_BANK, 32'h00000000);
        reg_check(`REG_WDOG, 32'h00000003);
        reg_write(`REG_SHADOW, 32'h00001234);
        reg_check(`REG_SHADOW, 32'h00000000);
        reg_write(4'hF, 32'hFFFFFFFF);
        reg_check(4'hF, 32'h00000000);
        reg_write(`REG_BANK, 32'h00000003);
        reg_write(`REG_ACC, 32'h0000005A);
        reg_write(`REG_FLAGS, 32'h00000001);
        reg_write(`REG_CTRL, 32'h00000001);
        reg_write(`REG_WDOG, 32'h00000000);
        reg_check(`REG_WDOG, 32'h00000000);
        check({30'h0, timeout_flag_n, powerdown_flag_n}, 32'h00000000);
        for (int i = 0; i < 1000 && u_exec_partner.n_fetch < 49; i++) begin
            @(posedge ref_clk);
        end
        if (u_exec_partner.n_fetch < 49) begin
            fails++;
            close_out();
        end
        #1;
        for (int i = 0; i < 32; i++) begin
            check({11'h0, u_exec_partner.fetch_log[i]}, 32'(i * 2));
        end
        for (int i = 0; i < 17; i++) begin
            check({11'h0, u_exec_partner.fetch_log[32 + i]}, {11'h0, exp_trace[i]});
        end
        for (int i = 0; i < 8; i++) begin
            check({24'h0, u_exec_partner.dmem[dm_addr[i]]}, {24'h0, dm_exp[i]});
        end
        check(32'(u_exec_partner.n_push), 32'h00000002);
        check({11'h0, u_exec_partner.push_log[0]}, 32'h00000058);
        check({11'h0, u_exec_partner.push_log[1]}, 32'h00024674);
        check(32'(u_exec_partner.n_kick), 32'h00000001);
        check({30'h0, timeout_flag_n, powerdown_flag_n}, 32'h00000003);
        reg_check(`REG_ACC, 32'h000000F0);
        reg_check(`REG_FLAGS, 32'h00000015);
        reg_check(`REG_BANK, 32'h00000003);
        reg_check(`REG_SHADOW, 32'h000071F0);
        reg_check(`REG_WDOG, 32'h00000003);
        reg_check(`REG_CTRL, 32'h00000001);
        close_out();
    end
endmodule

// ==== src/bank_addr_resolve.sv ====
`timescale 1ns/1ps
`include "bcce_regs.svh"

module bank_addr_resolve (
    input  wire logic        access_bit,
    input  wire logic [7:0]  f_field,
    input  wire logic [3:0]  bank,
    input  wire logic        ext_en,
    input  wire logic [11:0] index_base,
    output logic [11:0]      addr,
    output logic             indexed
);

    // ----------------------------------------
    // Bank / access / indexed address select
    // ----------------------------------------
    always_comb begin
        indexed = 1'b0;
        addr    = {bank, f_field};
        if (!access_bit) begin
            if (ext_en && (f_field <= `IDX_LIMIT)) begin
                indexed = 1'b1;
                addr    = index_base + {4'h0, f_field};
            end else if (f_field < `ACC_SPLIT) begin
                addr = {`ACC_LOW_BANK, f_field};
            end else begin
                addr = {`ACC_HIGH_BANK, f_field};
            end
        end
    end

endmodule

// ==== src/bcce_regs.svh ====
`ifndef BCCE_REGS_SVH
`define BCCE_REGS_SVH

// ----------------------------------------
// Register port map (word index)
// ----------------------------------------
`define REG_CTRL      4'h0
`define REG_PC        4'h1
`define REG_ACC       4'h2
`define REG_FLAGS     4'h3
`define REG_BANK      4'h4
`define REG_SHADOW    4'h5
`define REG_WDOG      4'h6

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_EXT      0
`define WDOG_PWRDN    0
`define WDOG_TO       1
`define ST_Z          2
`define ST_N          4
`define ST_RESET      5'h00
`define BANK_RESET    4'h0
`define ACC_RESET     8'h00

// ----------------------------------------
// Encodings and constants
// ----------------------------------------
`define PC_STEP       21'h000002
`define NOP_WORD      16'h0000
`define OPC_ZBRANCH   8'hE0
`define OPC_CALL      7'h76
`define OPC_CALL2     4'hF
`define OPC_CLEAR     7'h35
`define OPC_WDOG      16'h0004
`define OPC_INV       6'h07
`define CLR_VALUE     8'h00
`define IDX_LIMIT     8'h5F
`define ACC_SPLIT     8'h80
`define ACC_LOW_BANK  4'h0
`define ACC_HIGH_BANK 4'hF

`endif

// ==== src/branch_call_clear_exec.sv ====
// Operation
// - A zero-branch with Z set loads PC with the incremented PC plus twice the offset.
// - A taken zero-branch costs two cycles, the second a no-op; not taken, one cycle.
// - A call pushes PC+4 to the return stack and loads its 20-bit literal into PC<20:1>.
// - A call with the fast-save bit set copies W, flags and bank select into shadows.
// - A call is two words: 1110110s kkkkkkkk then 1111 with literal bits 19 to 8.
// - A call costs two cycles: push in Q3, high literal and PC write in Q4, then a no-op.
// - Clear-register writes 00h to the addressed register and sets Z in one cycle.
// - Access bit zero selects the access bank; one uses the bank select register.
// - Access bit zero with extended set and f at most 5Fh uses indexed offset addressing.
// - Watchdog clear pulses the counter reset and sets both active-low status bits.
// - Neither the zero-branch nor the call changes any status flag.
// - Invert complements the register into W when d is zero, else back into the register.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "bcce_regs.svh"

module branch_call_clear_exec
    import exec_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    output logic [20:0]      prog_addr,
    input  wire logic [15:0] prog_data,
    output dm_req_t          dm_req,
    input  wire logic [7:0]  dm_rdata,
    input  wire logic [11:0] index_base,
    output stack_push_t      return_stack_top,
    output logic             watchdog_clear,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    output q_phase_t         phase,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    q_phase_t    next_phase;
    logic [20:0] pc;
    logic [20:0] next_pc;
    logic [15:0] ir;
    logic [15:0] next_ir;
    logic        nop_cycle;
    logic        next_nop_cycle;
    logic [7:0]  accumulator_reg;
    logic [7:0]  next_accumulator_reg;
    logic [4:0]  flags_reg;
    logic [4:0]  next_flags_reg;
    logic [3:0]  bank_select_reg;
    logic [3:0]  next_bank_select_reg;
    logic [7:0]  working_shadow;
    logic [7:0]  next_working_shadow;
    logic [4:0]  flags_shadow;
    logic [4:0]  next_flags_shadow;
    logic [3:0]  bank_select_shadow;
    logic [3:0]  next_bank_select_shadow;
    logic        ext_en;
    logic        next_ext_en;
    logic        idx_mode;
    logic        next_idx_mode;
    dm_req_t     next_dm_req;
    stack_push_t next_return_stack_top;
    logic        next_watchdog_clear;
    logic        next_timeout_flag_n;
    logic        next_powerdown_flag_n;
    logic [31:0] next_reg_rdata;

    op_t         op;
    logic [11:0] res_addr;
    logic        res_idx;
    logic [7:0]  inv_result;
    logic [20:0] branch_target;
    logic [20:0] call_target;
    logic        call_word_ok;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_comb begin
        op = op_none;
        if (ir[15:8] == `OPC_ZBRANCH) begin
            op = op_zbranch;
        end else if (ir[15:9] == `OPC_CALL) begin
            op = op_call;
        end else if (ir[15:9] == `OPC_CLEAR) begin
            op = op_clear;
        end else if (ir == `OPC_WDOG) begin
            op = op_wdog;
        end else if (ir[15:10] == `OPC_INV) begin
            op = op_inv;
        end
    end

    assign inv_result    = ~dm_rdata;
    assign branch_target = pc + {{12{ir[7]}}, ir[7:0], 1'b0};
    assign call_target   = {prog_data[11:0], ir[7:0], 1'b0};
    assign call_word_ok  = (prog_data[15:12] == `OPC_CALL2);

    bank_addr_resolve u_resolve (
        .access_bit (prog_data[8]),
        .f_field    (prog_data[7:0]),
        .bank       (bank_select_reg),
        .ext_en     (ext_en),
        .index_base (index_base),
        .addr       (res_addr),
        .indexed    (res_idx)
    );

    // ----------------------------------------
    // Execution next state
    // ----------------------------------------
    always_comb begin
        next_phase              = phase;
        next_pc                 = pc;
        next_ir                 = ir;
        next_nop_cycle          = nop_cycle;
        next_accumulator_reg    = accumulator_reg;
        next_flags_reg          = flags_reg;
        next_bank_select_reg    = bank_select_reg;
        next_working_shadow     = working_shadow;
        next_flags_shadow       = flags_shadow;
        next_bank_select_shadow = bank_select_shadow;
        next_ext_en             = ext_en;
        next_idx_mode           = idx_mode;
        next_dm_req             = dm_req;
        next_dm_req.we          = 1'b0;
        next_return_stack_top       = return_stack_top;
        next_return_stack_top.valid = 1'b0;
        next_watchdog_clear     = 1'b0;
        next_timeout_flag_n     = timeout_flag_n;
        next_powerdown_flag_n   = powerdown_flag_n;

        // Software writes first, so core updates in the same cycle win
        if (reg_wr) begin
            case (reg_addr)
                `REG_CTRL:  next_ext_en = reg_wdata[`CTRL_EXT];
                `REG_ACC:   next_accumulator_reg = reg_wdata[7:0];
                `REG_FLAGS: next_flags_reg = reg_wdata[4:0];
                `REG_BANK:  next_bank_select_reg = reg_wdata[3:0];
                `REG_WDOG: begin
                    next_timeout_flag_n   = reg_wdata[`WDOG_TO];
                    next_powerdown_flag_n = reg_wdata[`WDOG_PWRDN];
                end
                default: ;
            endcase
        end

        unique case (phase)
            q1_decode: begin
                next_phase = q2_read;
                if (nop_cycle) begin
                    next_ir = `NOP_WORD;
                end else begin
                    next_ir = prog_data;
                    next_pc = pc + `PC_STEP;
                end
                next_dm_req.addr = res_addr;
                next_idx_mode    = res_idx;
            end
            q2_read: begin
                next_phase = q3_process;
            end
            q3_process: begin
                next_phase = q4_write;
                unique case (op)
                    op_call: begin
                        next_return_stack_top.valid = 1'b1;
                        next_return_stack_top.addr  = pc + `PC_STEP;
                        if (ir[8]) begin
                            next_working_shadow     = accumulator_reg;
                            next_flags_shadow       = flags_reg;
                            next_bank_select_shadow = bank_select_reg;
                        end
                    end
                    op_clear: begin
                        next_dm_req.we        = 1'b1;
                        next_dm_req.wdata     = `CLR_VALUE;
                        next_flags_reg[`ST_Z] = 1'b1;
                    end
                    op_wdog: begin
                        next_watchdog_clear   = 1'b1;
                        next_timeout_flag_n   = 1'b1;
                        next_powerdown_flag_n = 1'b1;
                    end
                    op_inv: begin
                        if (ir[9]) begin
                            next_dm_req.we    = 1'b1;
                            next_dm_req.wdata = inv_result;
                        end else begin
                            next_accumulator_reg = inv_result;
                        end
                        next_flags_reg[`ST_Z] = (inv_result == `CLR_VALUE);
                        next_flags_reg[`ST_N] = inv_result[7];
                    end
                    default: ;
                endcase
            end
            q4_write: begin
                next_phase     = q1_decode;
                next_nop_cycle = 1'b0;
                if (op == op_zbranch && flags_reg[`ST_Z]) begin
                    next_pc        = branch_target;
                    next_nop_cycle = 1'b1;
                end else if (op == op_call && call_word_ok) begin
                    next_pc        = call_target;
                    next_nop_cycle = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase              <= q1_decode;
            pc                 <= '0;
            ir                 <= `NOP_WORD;
            nop_cycle          <= 1'b0;
            accumulator_reg    <= `ACC_RESET;
            flags_reg          <= `ST_RESET;
            bank_select_reg    <= `BANK_RESET;
            working_shadow     <= `ACC_RESET;
            flags_shadow       <= `ST_RESET;
            bank_select_shadow <= `BANK_RESET;
            ext_en             <= 1'b0;
            idx_mode           <= 1'b0;
            dm_req             <= '0;
            return_stack_top   <= '0;
            watchdog_clear     <= 1'b0;
            timeout_flag_n     <= 1'b1;
            powerdown_flag_n   <= 1'b1;
        end else begin
            phase              <= next_phase;
            pc                 <= next_pc;
            ir                 <= next_ir;
            nop_cycle          <= next_nop_cycle;
            accumulator_reg    <= next_accumulator_reg;
            flags_reg          <= next_flags_reg;
            bank_select_reg    <= next_bank_select_reg;
            working_shadow     <= next_working_shadow;
            flags_shadow       <= next_flags_shadow;
            bank_select_shadow <= next_bank_select_shadow;
            ext_en             <= next_ext_en;
            idx_mode           <= next_idx_mode;
            dm_req             <= next_dm_req;
            return_stack_top   <= next_return_stack_top;
            watchdog_clear     <= next_watchdog_clear;
            timeout_flag_n     <= next_timeout_flag_n;
            powerdown_flag_n   <= next_powerdown_flag_n;
        end
    end

    assign prog_addr = pc;

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_comb begin
        next_reg_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:   next_reg_rdata = {31'h0, ext_en};
                `REG_PC:     next_reg_rdata = {11'h0, pc};
                `REG_ACC:    next_reg_rdata = {24'h0, accumulator_reg};
                `REG_FLAGS:  next_reg_rdata = {27'h0, flags_reg};
                `REG_BANK:   next_reg_rdata = {28'h0, bank_select_reg};
                `REG_SHADOW: next_reg_rdata = {15'h0, bank_select_shadow,
                                               flags_shadow, working_shadow};
                `REG_WDOG:   next_reg_rdata = {30'h0, timeout_flag_n, powerdown_flag_n};
                default:     next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_branch_target: assert property (
        phase == q4_write && op == op_zbranch && flags_reg[`ST_Z]
        |=> pc == $past(branch_target) && pc[0] == 1'b0)
        else $error("taken branch target wrong");

    chk_branch_fall: assert property (
        phase == q4_write && op == op_zbranch && !flags_reg[`ST_Z]
        |=> pc == $past(pc) && !nop_cycle)
        else $error("untaken branch changed pc or stalled");

    chk_nop_follows: assert property (
        phase == q4_write && ((op == op_zbranch && flags_reg[`ST_Z])
        || (op == op_call && call_word_ok))
        |=> nop_cycle [*4] ##1 !nop_cycle)
        else $error("no single no-op cycle after jump");

    chk_call_push: assert property (
        phase == q3_process && op == op_call
        |=> return_stack_top.valid && return_stack_top.addr == pc + `PC_STEP
        ##1 !return_stack_top.valid)
        else $error("call pushed wrong return address");

    chk_call_target: assert property (
        phase == q4_write && op == op_call && call_word_ok
        |=> pc == $past(call_target) && phase == q1_decode)
        else $error("call target wrong");

    chk_shadow_copy: assert property (
        phase == q3_process && op == op_call && ir[8]
        |=> working_shadow == $past(accumulator_reg)
            && flags_shadow == $past(flags_reg)
            && bank_select_shadow == $past(bank_select_reg))
        else $error("fast save did not copy");

    chk_shadow_hold: assert property (
        phase == q3_process && op == op_call && !ir[8]
        |=> $stable(working_shadow) && $stable(flags_shadow)
            && $stable(bank_select_shadow))
        else $error("shadows changed without fast save");

    chk_clear_write: assert property (
        phase == q3_process && op == op_clear
        |=> dm_req.we && dm_req.wdata == `CLR_VALUE && flags_reg[`ST_Z]
        ##1 !dm_req.we)
        else $error("clear did not write zero and set Z");

    chk_bank_select: assert property (
        phase == q2_read && !nop_cycle && ir[8]
        |-> dm_req.addr == {$past(bank_select_reg), ir[7:0]} && !idx_mode)
        else $error("banked address wrong");

    chk_indexed_mode: assert property (
        phase == q2_read && !nop_cycle && idx_mode
        |-> !ir[8] && $past(ext_en) && ir[7:0] <= `IDX_LIMIT
            && dm_req.addr == $past(index_base) + {4'h0, ir[7:0]})
        else $error("indexed address wrong");

    chk_wdog_clear: assert property (
        phase == q3_process && op == op_wdog
        |=> watchdog_clear && timeout_flag_n && powerdown_flag_n ##1 !watchdog_clear)
        else $error("watchdog clear incomplete");

    chk_flags_kept: assert property (
        (phase == q3_process || phase == q4_write)
        && (op == op_zbranch || op == op_call) && !reg_wr
        |=> $stable(flags_reg))
        else $error("branch or call altered flags");

    chk_invert_dest: assert property (
        phase == q3_process && op == op_inv
        |=> (ir[9] ? (dm_req.we && dm_req.wdata == ~$past(dm_rdata))
            : (!dm_req.we && accumulator_reg == ~$past(dm_rdata))))
        else $error("invert result misplaced");

endmodule

// ==== src/exec_pkg.sv ====
package exec_pkg;

    typedef enum logic [3:0] {
        q1_decode  = 4'h1,
        q2_read    = 4'h2,
        q3_process = 4'h4,
        q4_write   = 4'h8
    } q_phase_t;

    typedef enum logic [2:0] {
        op_none    = 3'h0,
        op_zbranch = 3'h1,
        op_call    = 3'h2,
        op_clear   = 3'h3,
        op_wdog    = 3'h4,
        op_inv     = 3'h5
    } op_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } dm_req_t;

    typedef struct packed {
        logic        valid;
        logic [20:0] addr;
    } stack_push_t;

endpackage
